// ### rtl/counter_array_pkg.sv
// constants and carriers shared by the counter array control/status block
// assumes an 8-bit special-function-register port of the host cpu
package counter_array_pkg;
  // register addresses in the sfr space
  localparam logic [7:0] ctrl_addr = 8'hd8;
  localparam logic [7:0] mode_addr = 8'hd9;
  // control register fields
  localparam int ctrl_ovf_bit = 7;
  localparam int ctrl_run_bit = 6;
  localparam int ctrl_rsv_bit = 5;
  localparam int mod_flag_msb = 4;
  localparam int mod_flag_lsb = 0;
  // mode register fields
  localparam int mode_idle_bit = 7;
  localparam int mode_wdt_bit = 6;
  localparam int mode_cps_msb = 2;
  localparam int mode_cps_lsb = 1;
  localparam int mode_ecf_bit = 0;
  // sizes and reset values
  localparam int num_modules = 5;
  localparam int count_width = 16;
  localparam logic [7:0] ctrl_reset = 8'h00;
  localparam logic [7:0] mode_reset = 8'h00;
  localparam logic [7:0] read_zero = 8'h00;
  localparam logic [count_width-1:0] count_reset = 16'h0000;
  localparam logic [count_width-1:0] count_step = 16'h0001;
  localparam logic [count_width-1:0] count_max = 16'hffff;
  localparam logic [num_modules-1:0] flags_none = 5'h00;

  typedef struct packed {
    logic ovf;
    logic run;
    logic [num_modules-1:0] mod_flags;
  } ctrl_t;

  typedef struct packed {
    logic idle_gate;
    logic wdt_en;
    logic [1:0] cps;
    logic ecf;
  } mode_t;

  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic [7:0] wdata;
  } sfr_req_t;
endpackage : counter_array_pkg

// ### rtl/counter_array_control_status.sv
// control/status core of the counter array: shared 16-bit time base,
// run and idle gating, overflow and per-module event flags.
// assumes count_tick_in is the already selected count strobe and that
// module events arrive as one-cycle strobes from the compare/capture units.
//
// Function
// - counter advances only while run bit set; stops when software clears it
// - counter rollover sets the overflow flag, control register bit 7
// - overflow raises interrupt request only while overflow interrupt enable set
// - overflow flag set by hardware or software; cleared only by software zero
// - module n event (match or capture) sets flag bit n, n 0..4
// - hardware never clears module flags; they hold until software writes zero
// - idle gate bit decides whether counter runs or halts in idle
// - idle gate one halts counting in idle; zero keeps counting
// - watchdog enable bit enables or disables the module 4 watchdog
// - overflow interrupt enable is mode register bit 0
// - mode register resets bits 7,6,2,1,0 to zero; not bit addressable
// - control register resets flags, run bit to zero; not bit addressable
`timescale 1ns/10ps
`default_nettype none

module counter_array_control_status
  import counter_array_pkg::*;
(
  // clock, reset, enable
  input wire logic clock_in,
  input wire logic srst_in,
  input wire logic ce_in,
  // sfr port
  input wire sfr_req_t sfr_req_in,
  output logic [7:0] sfr_rdata_out,
  // time base and events
  input wire logic count_tick_in,
  input wire logic cpu_idle_in,
  input wire logic [num_modules-1:0] module_event_in,
  // status out
  output logic [count_width-1:0] counter_out,
  output logic [1:0] count_source_sel_out,
  output logic module4_watchdog_enable_out,
  output logic overflow_irq_out,
  output logic [num_modules-1:0] module_flags_out
);

  ctrl_t ctrl_q;
  ctrl_t ctrl_d;
  mode_t mode_q;
  mode_t mode_d;
  logic [count_width-1:0] count_q;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic wr_ctrl;
  logic wr_mode;
  logic count_en;
  logic wrap;

  // byte-wide writes only; no single-bit access path exists
  assign wr_ctrl = sfr_req_in.wr && (sfr_req_in.addr == ctrl_addr);
  assign wr_mode = sfr_req_in.wr && (sfr_req_in.addr == mode_addr);

  // idle only gates when the idle gate bit is one
  assign count_en = ctrl_q.run && count_tick_in
                    && !(cpu_idle_in && mode_q.idle_gate);
  assign wrap = count_en && (count_q == count_max);

  // time base
  // no preload path: software can only stop and restart the count
  always_ff @(posedge clock_in)
  begin
    if (srst_in)
    begin
      count_q <= count_reset;
    end
    else if (ce_in && count_en)
    begin
      count_q <= count_q + count_step;
    end
  end

  // control register next value: hardware set wins over software clear
  always_comb
  begin
    ctrl_d = ctrl_q;
    if (wr_ctrl)
    begin
      ctrl_d.ovf = sfr_req_in.wdata[ctrl_ovf_bit];
      ctrl_d.run = sfr_req_in.wdata[ctrl_run_bit];
      ctrl_d.mod_flags = sfr_req_in.wdata[mod_flag_msb:mod_flag_lsb];
    end
    if (wrap)
    begin
      ctrl_d.ovf = 1'b1;
    end
    // events still land in idle and while a write is in flight
    ctrl_d.mod_flags = ctrl_d.mod_flags | module_event_in;
  end

  always_ff @(posedge clock_in)
  begin
    if (srst_in)
    begin
      ctrl_q.ovf <= ctrl_reset[ctrl_ovf_bit];
      ctrl_q.run <= ctrl_reset[ctrl_run_bit];
      ctrl_q.mod_flags <= ctrl_reset[mod_flag_msb:mod_flag_lsb];
    end
    else if (ce_in)
    begin
      ctrl_q <= ctrl_d;
    end
  end

  // mode register; reserved bits are not stored
  always_comb
  begin
    mode_d = mode_q;
    if (wr_mode)
    begin
      mode_d.idle_gate = sfr_req_in.wdata[mode_idle_bit];
      mode_d.wdt_en = sfr_req_in.wdata[mode_wdt_bit];
      mode_d.cps = sfr_req_in.wdata[mode_cps_msb:mode_cps_lsb];
      mode_d.ecf = sfr_req_in.wdata[mode_ecf_bit];
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (srst_in)
    begin
      // undefined bits of both registers come out of reset as zero
      mode_q.idle_gate <= mode_reset[mode_idle_bit];
      mode_q.wdt_en <= mode_reset[mode_wdt_bit];
      mode_q.cps <= mode_reset[mode_cps_msb:mode_cps_lsb];
      mode_q.ecf <= mode_reset[mode_ecf_bit];
    end
    else if (ce_in)
    begin
      mode_q <= mode_d;
    end
  end

  // read path; reserved bits read zero, other addresses read zero
  always_comb
  begin
    rdata_d = read_zero;
    if (sfr_req_in.addr == ctrl_addr)
    begin
      rdata_d[ctrl_ovf_bit] = ctrl_q.ovf;
      rdata_d[ctrl_run_bit] = ctrl_q.run;
      rdata_d[mod_flag_msb:mod_flag_lsb] = ctrl_q.mod_flags;
    end
    else if (sfr_req_in.addr == mode_addr)
    begin
      rdata_d[mode_idle_bit] = mode_q.idle_gate;
      rdata_d[mode_wdt_bit] = mode_q.wdt_en;
      rdata_d[mode_cps_msb:mode_cps_lsb] = mode_q.cps;
      rdata_d[mode_ecf_bit] = mode_q.ecf;
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (srst_in)
    begin
      rdata_q <= read_zero;
    end
    else if (ce_in)
    begin
      rdata_q <= rdata_d;
    end
  end

  // one-cycle read latency: data stands until the next enabled edge
  assign sfr_rdata_out = rdata_q;
  assign counter_out = count_q;
  assign count_source_sel_out = mode_q.cps;
  assign module4_watchdog_enable_out = mode_q.wdt_en;
  assign module_flags_out = ctrl_q.mod_flags;
  // flag sets silently while the enable is low
  assign overflow_irq_out = ctrl_q.ovf && mode_q.ecf;

  // checks; all sample on the rising edge and, except the reset-value checks, are muted while reset is held
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (srst_in);

  // time base
  run_stops_count_a: assert property (
    !ctrl_q.run |=> $stable(count_q))
    else $error("counter moved with run bit clear");

  run_write_a: assert property (
    ce_in && wr_ctrl |=> ctrl_q.run == $past(sfr_req_in.wdata[ctrl_run_bit]))
    else $error("run bit did not follow write");

  count_steps_a: assert property (
    ce_in && count_en && (count_q != count_max)
    |=> count_q == $past(count_q) + count_step)
    else $error("counter did not advance by one");

  no_tick_holds_a: assert property (
    !count_tick_in |=> $stable(count_q))
    else $error("counter moved without a tick");

  idle_halt_a: assert property (
    mode_q.idle_gate && cpu_idle_in |=> $stable(count_q))
    else $error("counter moved during gated idle");

  idle_runs_a: assert property (
    ce_in && !mode_q.idle_gate && cpu_idle_in && ctrl_q.run && count_tick_in
    |=> count_q != $past(count_q))
    else $error("counter halted in ungated idle");

  idle_gate_write_a: assert property (
    ce_in && wr_mode |=> mode_q.idle_gate == $past(sfr_req_in.wdata[mode_idle_bit]))
    else $error("idle gate bit did not follow write");

  wrap_sets_ovf_a: assert property (
    ce_in && wrap |=> ctrl_q.ovf && (count_q == count_reset))
    else $error("rollover did not set overflow flag");

  // overflow flag and its interrupt
  ovf_sticky_a: assert property (
    ctrl_q.ovf && !(ce_in && wr_ctrl) |=> ctrl_q.ovf)
    else $error("overflow flag cleared by hardware");

  ovf_sw_set_a: assert property (
    ce_in && wr_ctrl && sfr_req_in.wdata[ctrl_ovf_bit] |=> ctrl_q.ovf)
    else $error("software could not set overflow flag");

  ovf_sw_clear_a: assert property (
    ce_in && wr_ctrl && !sfr_req_in.wdata[ctrl_ovf_bit] && !wrap |=> !ctrl_q.ovf)
    else $error("software could not clear overflow flag");

  ovf_wrap_only_a: assert property (
    !ctrl_q.ovf && !wrap && !wr_ctrl |=> !ctrl_q.ovf)
    else $error("overflow flag set without rollover");

  irq_gated_a: assert property (
    !mode_q.ecf |-> !overflow_irq_out)
    else $error("interrupt raised with enable clear");

  irq_follows_a: assert property (
    ce_in && wrap && mode_q.ecf && !wr_mode |=> overflow_irq_out)
    else $error("enabled overflow gave no interrupt");

  ecf_write_a: assert property (
    ce_in && wr_mode |=> mode_q.ecf == $past(sfr_req_in.wdata[mode_ecf_bit]))
    else $error("overflow interrupt enable did not follow write");

  // per-module flags
  mod_flag_set_a: assert property (
    ce_in && (module_event_in != flags_none)
    |=> (ctrl_q.mod_flags & $past(module_event_in)) == $past(module_event_in))
    else $error("module event did not set its flag");

  mod_flag_hold_a: assert property (
    !(ce_in && wr_ctrl)
    |=> (ctrl_q.mod_flags & $past(ctrl_q.mod_flags)) == $past(ctrl_q.mod_flags))
    else $error("module flag cleared by hardware");

  mod_flag_write_a: assert property (
    ce_in && wr_ctrl
    |=> ctrl_q.mod_flags == ($past(sfr_req_in.wdata[mod_flag_msb:mod_flag_lsb]) | $past(module_event_in)))
    else $error("module flags did not follow write");

  // mode register and watchdog enable
  wdt_enable_a: assert property (
    ce_in && wr_mode |=> module4_watchdog_enable_out == $past(sfr_req_in.wdata[mode_wdt_bit]))
    else $error("watchdog enable did not follow write");

  wdt_holds_a: assert property (
    !(ce_in && wr_mode) |=> $stable(module4_watchdog_enable_out))
    else $error("watchdog enable changed without a write");

  // bus side and clock enable
  ce_freeze_a: assert property (
    !ce_in |=> $stable(count_q) && $stable(ctrl_q) && $stable(mode_q) && $stable(rdata_q))
    else $error("state moved with clock enable low");

  ctrl_rsv_read_a: assert property (
    ce_in && (sfr_req_in.addr == ctrl_addr) |=> sfr_rdata_out[ctrl_rsv_bit] == read_zero[ctrl_rsv_bit])
    else $error("reserved control bit read as one");

  ctrl_read_a: assert property (
    ce_in && (sfr_req_in.addr == ctrl_addr) |=> sfr_rdata_out[ctrl_ovf_bit] == $past(ctrl_q.ovf))
    else $error("overflow flag not visible on read");

  // reset values; checked through reset itself, so never disabled
  ctrl_reset_a: assert property (@(posedge clock_in) disable iff (1'b0)
    srst_in |=> ctrl_q.ovf == ctrl_reset[ctrl_ovf_bit] && ctrl_q.run == ctrl_reset[ctrl_run_bit]
    && ctrl_q.mod_flags == ctrl_reset[mod_flag_msb:mod_flag_lsb])
    else $error("control register not cleared by reset");

  mode_reset_a: assert property (@(posedge clock_in) disable iff (1'b0)
    srst_in |=> mode_q.idle_gate == mode_reset[mode_idle_bit] && mode_q.wdt_en == mode_reset[mode_wdt_bit]
    && mode_q.cps == mode_reset[mode_cps_msb:mode_cps_lsb] && mode_q.ecf == mode_reset[mode_ecf_bit])
    else $error("mode register not cleared by reset");

  count_reset_a: assert property (@(posedge clock_in) disable iff (1'b0)
    srst_in |=> count_q == count_reset && rdata_q == read_zero)
    else $error("counter or read data not cleared by reset");

endmodule : counter_array_control_status

`default_nettype wire

// ### verification/tb.sv
// self-checking bench for the counter array control/status block
// assumes one-cycle read latency on the sfr port
`timescale 1ns/10ps
`default_nettype none

module tb;
  import counter_array_pkg::*;

  logic clock_in = 1'b0;
  logic srst_in = 1'b1;
  logic ce_in = 1'b1;
  logic count_tick_in = 1'b0;
  logic cpu_idle_in = 1'b0;
  logic [num_modules-1:0] module_event_in = flags_none;
  sfr_req_t req = '0;
  logic [7:0] sfr_rdata_out;
  logic [count_width-1:0] counter_out;
  logic [1:0] count_source_sel_out;
  logic module4_watchdog_enable_out;
  logic overflow_irq_out;
  logic [num_modules-1:0] module_flags_out;
  int errors = 0;
  int total_checks = 0;

  counter_array_control_status DUT (
    .clock_in(clock_in), .srst_in(srst_in), .ce_in(ce_in), .sfr_req_in(req),
    .sfr_rdata_out(sfr_rdata_out), .count_tick_in(count_tick_in), .cpu_idle_in(cpu_idle_in),
    .module_event_in(module_event_in), .counter_out(counter_out),
    .count_source_sel_out(count_source_sel_out),
    .module4_watchdog_enable_out(module4_watchdog_enable_out),
    .overflow_irq_out(overflow_irq_out), .module_flags_out(module_flags_out)
  );

  initial
  begin
    forever #20 clock_in = ~clock_in;
  end

  task summarize;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : summarize

  task chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  // all tasks start and end 1 ns after a rising edge
  task wr(input logic [7:0] a, input logic [7:0] d);
    if (a == ctrl_addr && d[ctrl_rsv_bit])
    begin
      errors++;
      $display("mismatch at %0t: stimulus sets reserved control bit", $time);
    end
    req = '{addr: a, wr: 1'b1, wdata: d};
    @(posedge clock_in);
    #1 req.wr = 1'b0;
    // one idle edge so the next call never re-drives the strobe in this step
    @(posedge clock_in);
    #1;
  endtask : wr

  task rd(input logic [7:0] a, input logic [7:0] exp, input string msg);
    req.addr = a;
    req.wr = 1'b0;
    @(posedge clock_in);
    #1 chk({8'h00, sfr_rdata_out}, {8'h00, exp}, msg);
  endtask : rd

  // tick held high: one count per enabled cycle
  task tick(input int n);
    count_tick_in = 1'b1;
    repeat (n) @(posedge clock_in);
    #1 count_tick_in = 1'b0;
  endtask : tick

  task done(input string name);
    $display("test %s finished", name);
  endtask : done

  initial
  begin
    #(40 * 100000);
    errors++;
    $display("mismatch at %0t: run timed out", $time);
    summarize();
  end

  initial
  begin
    repeat (16) @(posedge clock_in);
    #1 srst_in = 1'b0;
    rd(ctrl_addr, 8'h00, "ctrl reset");
    rd(mode_addr, 8'h00, "mode reset");
    rd(8'h42, 8'h00, "unmapped read");
    chk(counter_out, 16'h0000, "counter reset");
    done("reset");
    wr(ctrl_addr, 8'h40);
    tick(3);
    chk(counter_out, 16'h0003, "run counts");
    wr(ctrl_addr, 8'h00);
    tick(3);
    chk(counter_out, 16'h0003, "stopped holds");
    done("run");
    wr(ctrl_addr, 8'h40);
    tick(16'hfffc);
    chk({15'h0, overflow_irq_out}, 16'h0, "no irq at max");
    chk(counter_out, 16'hffff, "counter at max");
    wr(mode_addr, 8'h01);
    tick(1);
    chk(counter_out, 16'h0000, "wrap to zero");
    rd(ctrl_addr, 8'hc0, "overflow set");
    chk({15'h0, overflow_irq_out}, 16'h1, "irq on wrap");
    wr(mode_addr, 8'h00);
    chk({15'h0, overflow_irq_out}, 16'h0, "irq masked");
    wr(mode_addr, 8'h01);
    chk({15'h0, overflow_irq_out}, 16'h1, "irq enabled");
    wr(ctrl_addr, 8'h40);
    chk({15'h0, overflow_irq_out}, 16'h0, "sw clear");
    wr(ctrl_addr, 8'hc0);
    rd(ctrl_addr, 8'hc0, "sw set");
    done("overflow");
    @(posedge clock_in);
    #1 module_event_in = 5'h15;
    @(posedge clock_in);
    #1 module_event_in = 5'h0a;
    @(posedge clock_in);
    #1 module_event_in = flags_none;
    chk({11'h0, module_flags_out}, 16'h001f, "module flags");
    repeat (5) @(posedge clock_in);
    #1 rd(ctrl_addr, 8'hdf, "flags held");
    wr(ctrl_addr, 8'h40);
    chk({11'h0, module_flags_out}, 16'h0000, "flags cleared");
    done("flags");
    wr(mode_addr, 8'h80);
    cpu_idle_in = 1'b1;
    tick(3);
    chk(counter_out, 16'h0000, "gated in idle");
    wr(mode_addr, 8'h00);
    tick(3);
    chk(counter_out, 16'h0003, "runs through idle");
    cpu_idle_in = 1'b0;
    done("idle");
    wr(mode_addr, 8'h40);
    chk({15'h0, module4_watchdog_enable_out}, 16'h1, "wdt enabled");
    wr(mode_addr, 8'hbf);
    chk({15'h0, module4_watchdog_enable_out}, 16'h0, "wdt off");
    chk({14'h0, count_source_sel_out}, 16'h3, "source select");
    rd(mode_addr, 8'h87, "mode reserved");
    done("mode");
    // clock enable low: writes, ticks and events are all ignored
    ce_in = 1'b0;
    module_event_in = 5'h01;
    wr(ctrl_addr, 8'h00);
    tick(3);
    chk(counter_out, 16'h0003, "frozen counter");
    chk({11'h0, module_flags_out}, 16'h0000, "frozen flags");
    rd(ctrl_addr, 8'h87, "frozen read");
    ce_in = 1'b1;
    module_event_in = flags_none;
    rd(ctrl_addr, 8'h40, "thawed read");
    done("enable");
    summarize();
  end
endmodule : tb

`default_nettype wire
